// *** dv/test_xdata_access_steering_dual_data_pointer.sv ***
`timescale 1ns/100ps
module test_xdata_access_steering_dual_data_pointer;
  logic clk = 1'b0, rstn = 1'b0, ard = 1'b0, awr = 1'b0, x;
  logic mreq = 1'b0, mw = 1'b0, mp = 1'b0, ms = 1'b0, pointer_low_byte = 1'b0, dpi = 1'b0;
  logic [7:0] aa = 8'h00, mri = 8'h00, mwd = 8'h00, b;
  logic [31:0] awd = 32'h0, q;
  logic [15:0] dpv = 16'h0;
  wire [31:0] ardq;
  wire [15:0] dpo;
  wire [7:0] mrd, lo_in, lo_out, hi;
  wire wreq, mdone, oe, wr_n, rd_n;
  int num_errors = 0, samples_checked = 0, c;
  always #4 clk = ~clk;
  xds_steer i_xds_steer (.i_clk_sys(clk), .i_rstn(rstn), .i_avs_address(aa),
    .i_avs_read(ard), .i_avs_write(awr), .i_avs_writedata(awd),
    .o_avs_readdata(ardq), .o_avs_waitrequest(wreq), .i_mv_req(mreq),
    .i_mv_write(mw), .i_mv_ptr_form(mp), .i_mv_ri_addr(mri),
    .i_mv_wdata(mwd), .i_mv_stack(ms), .o_mv_done(mdone), .o_mv_rdata(mrd),
    .i_dp_load(pointer_low_byte), .i_dp_load_val(dpv), .i_dp_inc(dpi), .o_dp_value(dpo),
    .i_lo_port(lo_in), .o_lo_port(lo_out), .o_lo_port_oe(oe),
    .o_hi_port(hi), .o_ext_wr_n(wr_n), .o_ext_rd_n(rd_n));
  xds_ext_mem i_xds_ext_mem (.i_clk_sys(clk), .i_lo(lo_out), .i_oe(oe),
    .i_hi(hi), .i_wr_n(wr_n), .i_rd_n(rd_n), .o_lo(lo_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    aa <= a;
    awd <= d;
    ard <= !w;
    awr <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = ardq;
    ard <= 1'b0;
    awr <= 1'b0;
    @(posedge clk);
  endtask
  // One move; notes pin activity, cycles to done and read byte
  task automatic mv(input logic w, p, s, input logic [7:0] r, d);
    mreq <= 1'b1;
    {mw, mp, ms, mri, mwd} <= {w, p, s, r, d};
    x = 1'b0;
    c = 0;
    @(posedge clk);
    mreq <= 1'b0;
    do begin
      @(posedge clk);
      c++;
      x = x | !wr_n | !rd_n | oe;
    end while (mdone !== 1'b1 && c < 40);
    if (mdone !== 1'b1) num_errors++;
    b = mrd;
    @(posedge clk);
  endtask
  // Pointer op, then time for the registered copy to settle
  task automatic ptr(input logic l, input logic [15:0] v, input logic i);
    {pointer_low_byte, dpv, dpi} <= {l, v, i};
    @(posedge clk);
    {pointer_low_byte, dpi} <= 2'b00;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_regs;
    bus(0, 8'hbc, 0); chk(q, 32'h1);
    bus(0, 8'h8e, 0); chk(q, 32'h0);
    bus(0, 8'ha2, 0); chk(q, 32'h0);
    bus(1, 8'ha2, 32'hff); bus(0, 8'ha2, 0); chk(q, 32'hfb);
    bus(1, 8'ha2, 32'h08); bus(0, 8'ha2, 0); chk(q, 32'h08);
    bus(1, 8'hc0, 32'h5a); bus(0, 8'hc0, 0); chk(q, 32'h0);
    bus(1, 8'ha2, 32'h00);
  endtask
  task automatic t_ptrs;
    ptr(1, 16'h0123, 0);
    bus(1, 8'ha2, 32'h01);
    ptr(1, 16'h0456, 0);
    ptr(0, 16'h0, 1); chk(dpo, 32'h0457);
    bus(0, 8'hb0, 0); chk(q, 32'h0123);
    bus(0, 8'hb4, 0); chk(q, 32'h0457);
    bus(0, 8'hb8, 0); chk(q, 32'h0457);
    bus(1, 8'ha2, 32'h00);
  endtask
  task automatic t_ram;
    ptr(1, 16'h02ff, 0);
    mv(1, 1, 0, 0, 8'h5a); chk(x, 0); chk(c, 2);
    mv(0, 1, 0, 0, 0); chk(b, 8'h5a); chk(x, 0);
    mv(1, 0, 0, 8'hff, 8'h33); chk(x, 0);
    ptr(1, 16'h00ff, 0);
    mv(0, 1, 0, 0, 0); chk(b, 8'h33);
  endtask
  task automatic t_ext;
    ptr(1, 16'h0300, 0);
    mv(1, 1, 0, 0, 8'ha5); chk(x, 1); chk(c, 7);
    chk(i_xds_ext_mem.mem[16'h0300], 8'ha5);
    mv(0, 1, 0, 0, 0); chk(b, 8'ha5);
    mv(1, 0, 1, 8'h30, 8'h77); chk(x, 1);
  endtask
  task automatic t_force;
    bus(1, 8'h8e, 32'h02);
    mv(1, 0, 0, 8'h20, 8'h44); chk(x, 1);
    chk(i_xds_ext_mem.addr_q[7:0], 8'h20);
    ptr(1, 16'h0010, 0);
    mv(1, 1, 0, 0, 8'h66); chk(x, 1);
    chk(i_xds_ext_mem.mem[16'h0010], 8'h66);
    bus(1, 8'h8e, 32'h00);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_ptrs;
    t_ram;
    t_ext;
    t_force;
    test_done;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    test_done;
  end
endmodule // test_xdata_access_steering_dual_data_pointer

// *** dv/xds_ext_mem.sv ***
`timescale 1ns/100ps
module xds_ext_mem (
  // Bus pins seen from memory
  input wire i_clk_sys,
  input wire [7:0] i_lo,
  input wire i_oe,
  input wire [7:0] i_hi,
  input wire i_wr_n,
  input wire i_rd_n,
  output wire [7:0] o_lo
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_q;
  logic [7:0] junk_q = 8'h5c;
  // Address phase is the driven span before any strobe
  always @(posedge i_clk_sys) begin
    junk_q <= ~junk_q + 8'h01;
    if (i_oe && i_wr_n && i_rd_n)
      addr_q <= {i_hi, i_lo};
    if (!i_wr_n)
      mem[addr_q] <= i_lo;
  end
  // Outside the read strobe the port shows a changing pattern, not data
  assign o_lo = !i_rd_n ? mem[addr_q] : junk_q;
endmodule // xds_ext_mem

// *** dv/xds_steer_props.sv ***
`timescale 1ns/100ps
module xds_steer_props (
  // Clock, reset and register bus
  input wire i_clk_sys,
  input wire i_rstn,
  input wire [7:0] i_avs_address,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire o_avs_waitrequest,
  // Moves and pointer
  input wire i_mv_req,
  input wire i_mv_ptr_form,
  input wire [7:0] i_mv_ri_addr,
  input wire i_mv_stack,
  input wire o_mv_done,
  input wire [15:0] o_dp_value,
  // Bus pins
  input wire [7:0] o_lo_port,
  input wire o_lo_port_oe,
  input wire [7:0] o_hi_port,
  input wire o_ext_wr_n,
  input wire o_ext_rd_n
);
  logic force_q, busy_q, gap_q;
  wire taken = i_mv_req && !busy_q && !gap_q;
  // Pointer value lags a cycle, so moves must not follow pointer ops closely
  wire ram_hit = taken && !force_q && !i_mv_stack &&
    (!i_mv_ptr_form || o_dp_value <= 16'h02ff);
  wire ext_go = taken && !ram_hit;
  // Mirror of the force bit and of the busy span of the sequencer
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      force_q <= 1'b0;
      busy_q <= 1'b0;
      gap_q <= 1'b0;
    end else begin
      if (i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h8e)
        force_q <= i_avs_writedata[1];
      busy_q <= taken || (busy_q && !o_mv_done);
      gap_q <= o_mv_done;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  sequence s_pins_idle;
    o_ext_wr_n && o_ext_rd_n && !o_lo_port_oe;
  endsequence
  sequence s_strobe;
    !o_ext_wr_n || !o_ext_rd_n;
  endsequence
  chk_wait_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_ram_done: assert property (ram_hit |-> ##2 o_mv_done)
    else $error("expanded ram move late");
  chk_ram_quiet: assert property (ram_hit |=> s_pins_idle [*2])
    else $error("expanded ram move touched pins");
  chk_ext_strobe: assert property (ext_go |-> ##[2:8] s_strobe)
    else $error("external move without strobe");
  chk_lo_addr: assert property (
    ext_go |=> o_lo_port_oe && o_lo_port ==
    ($past(i_mv_ptr_form) ? $past(o_dp_value[7:0]) : $past(i_mv_ri_addr)))
    else $error("low address byte wrong");
  chk_hi_addr: assert property (
    ext_go && i_mv_ptr_form |=> o_hi_port == $past(o_dp_value[15:8]))
    else $error("high address byte wrong");
  chk_one_strobe: assert property (!(!o_ext_wr_n && !o_ext_rd_n))
    else $error("both strobes low");
  chk_done_pulse: assert property (o_mv_done |=> !o_mv_done)
    else $error("done longer than one cycle");
endmodule // xds_steer_props
bind xds_steer xds_steer_props i_xds_steer_props (.i_clk_sys, .i_rstn,
  .i_avs_address, .i_avs_write, .i_avs_writedata, .o_avs_waitrequest,
  .i_mv_req, .i_mv_ptr_form, .i_mv_ri_addr, .i_mv_stack, .o_mv_done,
  .o_dp_value, .o_lo_port, .o_lo_port_oe, .o_hi_port, .o_ext_wr_n,
  .o_ext_rd_n);

// *** rtl/xds_consts.vh ***
`ifndef XDS_CONSTS_VH
`define XDS_CONSTS_VH
// Register word offsets (byte address on the bus, one word per register)
`define XDS_OFF_AUX_CONTROL 8'h8e
`define XDS_OFF_POINTER_CONTROL 8'ha2
`define XDS_OFF_DATA_POINTER_FIRST 8'hb0
`define XDS_OFF_DATA_POINTER_SECOND 8'hb4
`define XDS_OFF_DATA_POINTER_ACTIVE 8'hb8
`define XDS_OFF_STATUS 8'hbc
// Field positions
`define XDS_BIT_FORCE_EXT 1
`define XDS_BIT_ALE_OFF 0
`define XDS_BIT_SELECT 0
`define XDS_BIT_USER_FLAG 3
`define XDS_BIT_HARD_ZERO 2
// Reset values
`define XDS_RST_AUX_CONTROL 8'h00
`define XDS_RST_POINTER_CONTROL 8'h00
// Address limits
`define XDS_EXPANDED_RAM_TOP 16'h02ff
`define XDS_EXPANDED_RAM_WORDS 768
`define XDS_RI_TOP 16'h00ff
// External bus cycle phases, in clocks
`define XDS_PH_ADDR 2
`define XDS_PH_STROBE 4
`endif

// *** rtl/xds_expanded_ram.v ***
`timescale 1ns/100ps
// On-chip expanded RAM, single port, one-cycle synchronous read
module xds_expanded_ram #(
  parameter DEPTH = 768,
  parameter AW = 10
) (
  // Clock
  input wire i_clk_sys,
  // Access port
  input wire i_we,
  input wire [AW-1:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata
);
  reg [7:0] mem [0:DEPTH-1];

  // Write lands in this edge; read data valid next cycle
  always @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule // xds_expanded_ram

// *** rtl/xds_steer.v ***
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "xds_consts.vh"
module xds_steer (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rstn,
  // Avalon-MM register slave
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // Core move request
  input wire i_mv_req,
  input wire i_mv_write,
  input wire i_mv_ptr_form,
  input wire [7:0] i_mv_ri_addr,
  input wire [7:0] i_mv_wdata,
  input wire i_mv_stack,
  output reg o_mv_done,
  output reg [7:0] o_mv_rdata,
  // Core pointer operations
  input wire i_dp_load,
  input wire [15:0] i_dp_load_val,
  input wire i_dp_inc,
  output reg [15:0] o_dp_value,
  // External bus pins
  input wire [7:0] i_lo_port,
  output reg [7:0] o_lo_port,
  output reg o_lo_port_oe,
  output reg [7:0] o_hi_port,
  output reg o_ext_wr_n,
  output reg o_ext_rd_n
);
  // Read-back mask for pointer control; the hard-zero bit never shows
  localparam [7:0] HARD_ZERO_MASK = ~(8'h01 << `XDS_BIT_HARD_ZERO);

  // Move sequencer states; one hot so each state is a single flop
  // RAM hits pass IDLE, RAM, DONE; external moves IDLE, ADDR, STRB, DONE
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RAM = 5'h02;
  localparam [4:0] S_ADDR = 5'h04;
  localparam [4:0] S_STRB = 5'h08;
  localparam [4:0] S_DONE = 5'h10;

  reg [7:0] aux_control_q;
  reg [7:0] pointer_control_q;
  wire [15:0] data_pointer_first;
  wire [15:0] data_pointer_second;
  reg [4:0] state_q;
  reg [2:0] cnt_q;
  reg [15:0] addr_q;
  reg [7:0] wdata_q;
  reg write_q;
  reg ri_form_q;
  reg bus_busy_q;
  reg [9:0] ram_addr;
  reg ram_we;
  wire [7:0] ram_rdata;
  wire force_external_bit;
  wire pointer_select;
  wire [15:0] data_pointer;
  wire [15:0] mv_addr;
  wire to_ram;
  wire reg_wr;
  reg [31:0] reg_rd;

  assign force_external_bit = aux_control_q[`XDS_BIT_FORCE_EXT];
  assign pointer_select = pointer_control_q[`XDS_BIT_SELECT];
  // Selected pointer feeds pointer-form moves
  assign data_pointer = pointer_select ? data_pointer_second :
                        data_pointer_first;
  assign mv_addr = i_mv_ptr_form ? data_pointer :
                   {8'h00, i_mv_ri_addr};
  // Steering decision, made on the request cycle itself:
  // force bit set sends every move out on the bus;
  // pointer form at or below the RAM top stays on chip;
  // register-indirect form stays on chip, low 256 bytes only, unless it is stack traffic.
  // Stack traffic never steers into expanded RAM; it goes out as usual
  // only if the core mistakenly routes it here, so treat it as external
  // Limitation: the compare uses the live pointer, so a pointer load in
  // the same cycle as the move is not seen by that move
  assign to_ram = !force_external_bit && !i_mv_stack && (!i_mv_ptr_form ||
                  mv_addr <= `XDS_EXPANDED_RAM_TOP);

  // Register file accesses are single-cycle: one wait cycle then done
  // A write lands only at the edge where waitrequest is already low, so
  // a held request never writes twice
  assign reg_wr = i_avs_write && o_avs_waitrequest == 1'b0;

  // Readback mux; bit 2 of pointer control is forced low
  // Unmapped offsets read zero and never stall the bus
  // Status shows the last move address, its form, busy and the state
  always @* begin
    reg_rd = 32'h00000000;
    case (i_avs_address)
      `XDS_OFF_AUX_CONTROL: begin
        reg_rd = {24'h000000, aux_control_q};
      end
      `XDS_OFF_POINTER_CONTROL: begin
        reg_rd = {24'h000000, pointer_control_q & HARD_ZERO_MASK};
      end
      `XDS_OFF_DATA_POINTER_FIRST: begin
        reg_rd = {16'h0000, data_pointer_first};
      end
      `XDS_OFF_DATA_POINTER_SECOND: begin
        reg_rd = {16'h0000, data_pointer_second};
      end
      `XDS_OFF_DATA_POINTER_ACTIVE: begin
        reg_rd = {16'h0000, data_pointer};
      end
      `XDS_OFF_STATUS: begin
        reg_rd = {addr_q, 9'h000, ri_form_q, bus_busy_q, state_q};
      end
      default: begin
        reg_rd = 32'h00000000;
      end
    endcase
  end

  // Avalon slave: waitrequest drops one cycle after a request appears
  // Read data are captured with the drop, so they stand at the edge
  // where the master samples waitrequest low
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else begin
      if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b0;
        o_avs_readdata <= reg_rd;
      end else begin
        o_avs_waitrequest <= 1'b1;
      end
    end
  end

  // Control registers; reserved bits are stored but carry no function
  // Aux control bit 0 is kept for software only; no strobe depends on it
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      aux_control_q <= `XDS_RST_AUX_CONTROL;
      pointer_control_q <= `XDS_RST_POINTER_CONTROL;
    end else if (reg_wr) begin
      if (i_avs_address == `XDS_OFF_AUX_CONTROL) begin
        aux_control_q <= i_avs_writedata[7:0];
      end
      if (i_avs_address == `XDS_OFF_POINTER_CONTROL) begin
        // Bit 3 is a plain flag; bit 2 stored as zero
        pointer_control_q <= i_avs_writedata[7:0] & HARD_ZERO_MASK;
      end
    end
  end

  // Data pointers; core ops win over a same-cycle bus write of that pointer
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptr
      reg [15:0] value_q;
      wire hit_bus;
      wire hit_core;
      // Each pointer has its own bus offset
      assign hit_bus = reg_wr && i_avs_address ==
        ((gi == 0) ? `XDS_OFF_DATA_POINTER_FIRST : `XDS_OFF_DATA_POINTER_SECOND);
      // Only the selected pointer sees core loads and increments
      assign hit_core = (i_dp_load || i_dp_inc) &&
        (pointer_select == (gi == 1));
      // Load wins over increment; unselected pointer holds
      always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          value_q <= 16'h0000;
        end else if (hit_core) begin
          value_q <= i_dp_load ? i_dp_load_val :
                     value_q + 16'h0001;
        end else if (hit_bus) begin
          value_q <= i_avs_writedata[15:0];
        end
      end
    end
  endgenerate

  // Named views of the two pointers
  assign data_pointer_first = g_ptr[0].value_q;
  assign data_pointer_second = g_ptr[1].value_q;

  // Registered view of the active pointer
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dp_value <= 16'h0000;
    end else begin
      o_dp_value <= data_pointer;
    end
  end

  // RAM port: register-indirect form keeps to the low 256 bytes
  // The write strobe is taken on the request edge itself, so the byte
  // is stored before the move reports done
  always @* begin
    ram_we = 1'b0;
    ram_addr = mv_addr[9:0];
    if (!i_mv_ptr_form) begin
      ram_addr = {2'b00, mv_addr[7:0]};
    end
    if (state_q == S_IDLE && i_mv_req && to_ram && i_mv_write) begin
      ram_we = 1'b1;
    end
  end

  xds_expanded_ram #(
    .DEPTH(`XDS_EXPANDED_RAM_WORDS),
    .AW(10)
  ) u_expanded_ram (
    .i_clk_sys(i_clk_sys),
    .i_we(ram_we),
    .i_addr(ram_addr),
    .i_wdata(i_mv_wdata),
    .o_rdata(ram_rdata)
  );

  // Move sequencer: RAM hit done in two clocks, external cycle in more
  // External walk, counted from the taking edge c0:
  //   c0 low port gets the address byte, high port the pointer high byte in pointer form
  //   c2 low port gets write data (or is released), one strobe drops
  //   c6 read byte sampled, strobes rise, low port released, done pulses
  //   c7 settle cycle, then idle again
  // RAM walk: c0 taken, c1 read data captured with done, c2 settle.
  // The settle cycle trades one clock for safety against a held request.
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= S_IDLE;
      cnt_q <= 3'h0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      write_q <= 1'b0;
      ri_form_q <= 1'b0;
      bus_busy_q <= 1'b0;
      o_mv_done <= 1'b0;
      o_mv_rdata <= 8'h00;
      o_lo_port <= 8'h00;
      o_lo_port_oe <= 1'b0;
      o_hi_port <= 8'h00;
      o_ext_wr_n <= 1'b1;
      o_ext_rd_n <= 1'b1;
    end else begin
      o_mv_done <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (i_mv_req) begin
            addr_q <= mv_addr;
            wdata_q <= i_mv_wdata;
            write_q <= i_mv_write;
            ri_form_q <= !i_mv_ptr_form;
            if (to_ram) begin
              // Pins untouched for RAM hits
              state_q <= S_RAM;
            end else begin
              // Address phase: low port carries address byte
              o_lo_port <= mv_addr[7:0];
              o_lo_port_oe <= 1'b1;
              if (i_mv_ptr_form) begin
                o_hi_port <= mv_addr[15:8];
              end
              bus_busy_q <= 1'b1;
              cnt_q <= 3'h0;
              state_q <= S_ADDR;
            end
          end
        end
        S_RAM: begin
          o_mv_rdata <= ram_rdata;
          o_mv_done <= 1'b1;
          state_q <= S_DONE;
        end
        S_ADDR: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == (`XDS_PH_ADDR - 1)) begin
            cnt_q <= 3'h0;
            // Data phase: drive write data or release for read
            o_lo_port <= wdata_q;
            o_lo_port_oe <= write_q;
            o_ext_wr_n <= !write_q;
            o_ext_rd_n <= write_q;
            state_q <= S_STRB;
          end
        end
        S_STRB: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == (`XDS_PH_STROBE - 1)) begin
            cnt_q <= 3'h0;
            if (!write_q) begin
              o_mv_rdata <= i_lo_port; // Sampled before strobe rises
            end
            o_ext_wr_n <= 1'b1;
            o_ext_rd_n <= 1'b1;
            o_lo_port_oe <= 1'b0;
            bus_busy_q <= 1'b0;
            o_mv_done <= 1'b1;
            state_q <= S_DONE;
          end
        end
        S_DONE: begin
          // One settle cycle so a held request is not taken twice
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // xds_steer
